/* File: svs_cfg.svh */
`ifndef SVS_CFG_SVH
`define SVS_CFG_SVH

// Timebase rate
`define SVS_CLK_MHZ 125
// Reset hold time, least value
`define SVS_HOLD_TIME_MS 150
// Watchdog period, inside its 1.00 s to 2.25 s range
`define SVS_WDOG_TIME_MS 1600
// Manual reset debounce window
`define SVS_DEBOUNCE_TIME_NS 1000

// Cycle counts derived from the times (least times round up)
`define SVS_HOLD_CYCLES (`SVS_HOLD_TIME_MS * 1000 * `SVS_CLK_MHZ)
`define SVS_WDOG_CYCLES (`SVS_WDOG_TIME_MS * 1000 * `SVS_CLK_MHZ)
`define SVS_DEBOUNCE_CYCLES ((`SVS_DEBOUNCE_TIME_NS * `SVS_CLK_MHZ + 999) / 1000)

// Counter width, wide enough for the watchdog count
`define SVS_CNT_WIDTH 28

`endif

/* File: svs_pkg.sv */
package svs_pkg;

  // Reset pin variants
  typedef enum logic [1:0] {
    SVS_HIGH_OD,
    SVS_LOW_PP,
    SVS_LOW_OD
  } svs_polarity_type;

  // Supervisor states
  typedef enum {
    ST_ASSERT,
    ST_HOLD,
    ST_RUN,
    ST_BACKUP
  } svs_state_type;

  // Comparator results, modelled as digital levels
  typedef struct packed {
    logic belowThreshold;  // Main supply below reset_threshold
    logic backupAhead;     // backup_supply above main by 20 mV
    logic mainAhead;       // Main above backup_supply by 20 mV
    logic auxHigh;         // Aux monitor above its 1.235 V reference
  } svs_cond_type;

endpackage

/* File: svs_timer.sv */
`timescale 1ns/100ps
module svs_timer #(
  parameter int WIDTH    = 28,
  parameter int TERMINAL = 2
) (
  input  wire logic             mclk,   // Timebase clock
  input  wire logic             rstn,   // Sync reset, active low
  input  wire logic             clear,  // Return count to zero
  input  wire logic             run,    // Count while high
  output logic      [WIDTH-1:0] count,  // Current count
  output logic                  done    // Terminal count reached
);

  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] lastCount;

  assign lastCount = WIDTH'(TERMINAL - 1);
  assign done      = run && (count == lastCount);

  // Next count, clear has priority
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (run && !done) begin
      next_count = count + WIDTH'(1);
    end
  end

  // Count register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

/* File: svs_supervisor.sv */
// Notes on behaviour
// - Reset held while any cause is present
// - Reset held hold time after causes clear
// - Reset pin polarity and drive fixed per variant
// - Undriven manual reset reads as z, no pull-up
// - Bouncing manual reset gives one sequence
// - Stuck watchdog input triggers timed reset pulse
// - Watchdog cleared by reset or input edge
// - Watchdog timeout gives pulse, not level
// - Backup flag high in backup, else low
// - Backup needs below threshold and below backup
// - Switchover uses 20 mV margins each way
// - Output follows main above threshold
// - Never power up from backup alone
// - Aux monitor low asserts reset, then hold
// - Repeated pulses while watchdog input stuck
`timescale 1ns/100ps
`include "svs_cfg.svh"
module svs_supervisor #(
  parameter svs_pkg::svs_polarity_type POLARITY = svs_pkg::SVS_LOW_PP,
  parameter int HOLD_CYCLES = `SVS_HOLD_CYCLES,
  parameter int WDOG_CYCLES = `SVS_WDOG_CYCLES
) (
  input  wire logic                 mclk,                // Timebase clock
  input  wire logic                 rstn,                // Sync reset, active low
  input  wire svs_pkg::svs_cond_type supplyCond,         // Comparator levels
  input  wire logic                 manual_reset_n,      // Manual reset, active low
  input  wire logic                 watchdog_toggle_in,  // Watchdog toggle
  output logic                      resetOut,            // Reset pin output value
  output logic                      resetOe,             // Reset pin drive enable
  output logic                      on_backup_flag,      // High in backup mode
  output logic                      selBackup            // Switched output from backup
);

  localparam int CW = `SVS_CNT_WIDTH;

  svs_pkg::svs_cond_type condMeta, condSync;
  logic mrMeta, mrSync, mrFilt, wdiMeta, wdiSync, wdiLast, poweredUp;
  logic next_mrFilt, next_poweredUp, next_selBackup, next_resetOut, next_resetOe;
  logic causeActive, resetActive, wdEdge, holdDone, wdDone, debDone;
  logic [CW-1:0] wdCount;
  svs_pkg::svs_state_type state, next_state;

  // Two-stage synchronisers on every pin
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      condMeta <= 4'h8;
      condSync <= 4'h8;
      mrMeta   <= 1'h1;
      mrSync   <= 1'h1;
      wdiMeta  <= 1'h0;
      wdiSync  <= 1'h0;
      wdiLast  <= 1'h0;
    end else begin
      condMeta <= supplyCond;
      condSync <= condMeta;
      mrMeta   <= manual_reset_n;
      mrSync   <= mrMeta;
      wdiMeta  <= watchdog_toggle_in;
      wdiSync  <= wdiMeta;
      wdiLast  <= wdiSync;
    end
  end

  // Manual reset debounce: level must stand a full window
  svs_timer #(.WIDTH(CW), .TERMINAL(`SVS_DEBOUNCE_CYCLES)) debTimer (
    .mclk  (mclk),
    .rstn  (rstn),
    .clear (mrSync == mrFilt),
    .run   (1'b1),
    .count (),
    .done  (debDone)
  );

  // Reset hold timer, runs only in hold state
  svs_timer #(.WIDTH(CW), .TERMINAL(HOLD_CYCLES)) holdTimer (
    .mclk  (mclk),
    .rstn  (rstn),
    .clear (state != svs_pkg::ST_HOLD),
    .run   (state == svs_pkg::ST_HOLD),
    .count (),
    .done  (holdDone)
  );

  // Watchdog timer
  svs_timer #(.WIDTH(CW), .TERMINAL(WDOG_CYCLES)) wdTimer (
    .mclk  (mclk),
    .rstn  (rstn),
    .clear (resetActive || wdEdge),
    .run   (state == svs_pkg::ST_RUN),
    .count (wdCount),
    .done  (wdDone)
  );

  // Causes and edges
  assign wdEdge      = wdiSync ^ wdiLast;
  assign causeActive = condSync.belowThreshold || !mrFilt || !condSync.auxHigh;
  assign resetActive = (state != svs_pkg::ST_RUN);

  // Filter, power-up and switchover next values
  always_comb begin
    next_mrFilt    = debDone ? mrSync : mrFilt;
    next_poweredUp = poweredUp || !condSync.belowThreshold;
    next_selBackup = selBackup;
    if (!poweredUp || !condSync.belowThreshold) begin
      next_selBackup = 1'b0;
    end else if (condSync.backupAhead) begin
      next_selBackup = 1'b1;
    end else if (condSync.mainAhead) begin
      next_selBackup = 1'b0;
    end
  end

  // Supervisor state next value
  always_comb begin
    next_state = state;
    case (state)
      svs_pkg::ST_ASSERT: next_state = causeActive ? svs_pkg::ST_ASSERT : svs_pkg::ST_HOLD;
      svs_pkg::ST_HOLD: begin
        if (causeActive) begin
          next_state = svs_pkg::ST_ASSERT;
        end else if (holdDone) begin
          next_state = svs_pkg::ST_RUN;
        end
      end
      svs_pkg::ST_RUN: begin
        if (causeActive) begin
          next_state = svs_pkg::ST_ASSERT;
        end else if (wdDone) begin
          next_state = svs_pkg::ST_HOLD;
        end
      end
      svs_pkg::ST_BACKUP: next_state = svs_pkg::ST_ASSERT;
      default: next_state = svs_pkg::ST_ASSERT;
    endcase
    if (selBackup) begin
      next_state = svs_pkg::ST_BACKUP;
    end
  end

  // Pin drive from next state
  always_comb begin
    next_resetOut = 1'b0;
    next_resetOe  = 1'b1;
    case (POLARITY)
      svs_pkg::SVS_HIGH_OD: next_resetOe = (next_state == svs_pkg::ST_RUN);
      svs_pkg::SVS_LOW_OD:  next_resetOe = (next_state != svs_pkg::ST_RUN);
      default:              next_resetOut = (next_state == svs_pkg::ST_RUN);
    endcase
  end

  // State registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state          <= svs_pkg::ST_ASSERT;
      mrFilt         <= 1'b1;
      poweredUp      <= 1'b0;
      selBackup      <= 1'b0;
      on_backup_flag <= 1'b0;
      resetOut       <= 1'b0;
      resetOe        <= (POLARITY != svs_pkg::SVS_HIGH_OD);  // Undriven pin reads asserted on high variant
    end else begin
      state          <= next_state;
      mrFilt         <= next_mrFilt;
      poweredUp      <= next_poweredUp;
      selBackup      <= next_selBackup;
      on_backup_flag <= next_selBackup;
      resetOut       <= next_resetOut;
      resetOe        <= next_resetOe;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_cause_holds;
    causeActive |=> resetActive;
  endproperty
  a_cause_holds: assert property (p_cause_holds) else $error("reset released with a cause present");

  property p_hold_time;
    (state == svs_pkg::ST_HOLD) && !causeActive && !selBackup && !holdDone |=> resetActive;
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("hold ended early");

  property p_hold_exit;
    $rose(state == svs_pkg::ST_RUN) |-> $past(holdDone);
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("release without full hold");

  property p_pin_drive;
    ##1 (POLARITY == svs_pkg::SVS_LOW_PP) |-> (resetOut == !resetActive) && resetOe;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("push-pull pin mismatch");

  property p_debounce;
    $rose(mrSync != mrFilt) |-> $stable(mrFilt) [*8];
  endproperty
  a_debounce: assert property (p_debounce) else $error("manual reset taken without settling");

  property p_wd_pulse;
    (state == svs_pkg::ST_RUN) && wdDone && !causeActive && !selBackup |=> (state == svs_pkg::ST_HOLD) ##1 resetActive;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog expiry gave no pulse");

  property p_wd_clear;
    wdEdge || resetActive |=> (wdCount == '0);
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared");

  property p_flag;
    on_backup_flag == selBackup;
  endproperty
  a_flag: assert property (p_flag) else $error("backup flag mismatch");

  property p_backup_entry;
    $rose(selBackup) |-> $past(condSync.belowThreshold && condSync.backupAhead && poweredUp);
  endproperty
  a_backup_entry: assert property (p_backup_entry) else $error("illegal backup entry");

  property p_main_above;
    !$past(condSync.belowThreshold) |-> !selBackup;
  endproperty
  a_main_above: assert property (p_main_above) else $error("backup used above threshold");

  property p_startup;
    !poweredUp |-> !selBackup;
  endproperty
  a_startup: assert property (p_startup) else $error("backup used at startup");

  property p_backup_reset;
    selBackup |=> (state == svs_pkg::ST_BACKUP);
  endproperty
  a_backup_reset: assert property (p_backup_reset) else $error("reset released in backup");

  c_release: cover property ($rose(state == svs_pkg::ST_RUN));
  c_wd_expire: cover property ((state == svs_pkg::ST_RUN) && wdDone);
  c_backup: cover property ($rose(selBackup));
  c_mr_press: cover property ($fell(mrFilt));

endmodule

/* File: svs_partner.sv */
`timescale 1ns/100ps
module svs_partner #(
  parameter svs_pkg::svs_polarity_type POLARITY = svs_pkg::SVS_LOW_PP
) (
  input  wire logic mclk,                // Timebase clock
  input  wire logic toggleEn,            // Firmware alive
  input  wire logic resetOut,            // Reset pin value
  input  wire logic resetOe,             // Reset pin enable
  output logic      watchdog_toggle_in,  // Watchdog line
  output logic      inReset              // Processor held in reset
);
  logic [4:0] holdCnt;
  logic       pinLevel;

  // Pin level with the board pull-up when undriven
  assign pinLevel = resetOe ? resetOut : 1'b1;
  assign inReset  = (POLARITY == svs_pkg::SVS_HIGH_OD) ? pinLevel : !pinLevel;

  initial begin
    watchdog_toggle_in = 1'b0;
    holdCnt            = 5'h00;
  end

  // Toggle every 20 cycles, well above the 13 cycle minimum
  always @(negedge mclk) begin
    if (toggleEn && !inReset) begin
      holdCnt <= (holdCnt == 5'h13) ? 5'h00 : holdCnt + 5'h01;
      if (holdCnt == 5'h13) begin
        watchdog_toggle_in <= !watchdog_toggle_in;
      end
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  localparam int HOLD = 20;
  localparam int WDOG = 50;
  logic                  mclk, rstn, manualN, toggleEn, wdIn, rstA, rstB;
  logic                  outA, oeA, outB, oeB, flag, selB, outC, oeC, rstC;
  svs_pkg::svs_cond_type cond;
  int                    fail_count, comparisons;

  svs_supervisor #(.POLARITY(svs_pkg::SVS_LOW_PP), .HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG)) svs_supervisor_inst (
    .mclk(mclk), .rstn(rstn), .supplyCond(cond), .manual_reset_n(manualN), .watchdog_toggle_in(wdIn),
    .resetOut(outA), .resetOe(oeA), .on_backup_flag(flag), .selBackup(selB));
  svs_supervisor #(.POLARITY(svs_pkg::SVS_HIGH_OD), .HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG)) svs_supervisor_hi_inst (
    .mclk(mclk), .rstn(rstn), .supplyCond(cond), .manual_reset_n(manualN), .watchdog_toggle_in(wdIn),
    .resetOut(outB), .resetOe(oeB), .on_backup_flag(), .selBackup());
  svs_partner #(.POLARITY(svs_pkg::SVS_LOW_PP)) svs_partner_inst (
    .mclk(mclk), .toggleEn(toggleEn), .resetOut(outA), .resetOe(oeA), .watchdog_toggle_in(wdIn), .inReset(rstA));
  svs_partner #(.POLARITY(svs_pkg::SVS_HIGH_OD)) svs_partner_hi_inst (
    .mclk(mclk), .toggleEn(1'b0), .resetOut(outB), .resetOe(oeB), .watchdog_toggle_in(), .inReset(rstB));
  svs_supervisor #(.POLARITY(svs_pkg::SVS_LOW_OD), .HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG)) svs_supervisor_od_inst (
    .mclk(mclk), .rstn(rstn), .supplyCond(cond), .manual_reset_n(manualN), .watchdog_toggle_in(wdIn),
    .resetOut(outC), .resetOe(oeC), .on_backup_flag(), .selBackup());
  svs_partner #(.POLARITY(svs_pkg::SVS_LOW_OD)) svs_partner_od_inst (
    .mclk(mclk), .toggleEn(1'b0), .resetOut(outC), .resetOe(oeC), .watchdog_toggle_in(), .inReset(rstC));

  task automatic check(input string what, input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Bounded wait for the processor reset state
  task automatic wait_rst(input logic want, input int bound);
    for (int i = 0; i < bound && rstA !== want; i++) @(negedge mclk);
    if (rstA !== want) begin
      check("reset wait", rstA, want);
      give_verdict();
    end
  endtask

  // Reset state must stand for n cycles, all three variants alike
  task automatic keep_rst(input logic want, input int n);
    repeat (n) begin
      check("reset level", rstA, want);
      check("open drain variant", rstB, rstA);
      check("low open drain variant", rstC, rstA);
      @(negedge mclk);
    end
  endtask

  task automatic t_power();
    cond = 4'hD;
    keep_rst(1'b1, 30);
    check("backup sel", selB, 1'b0);
    check("backup flag", flag, 1'b0);
    cond = 4'h1;
    keep_rst(1'b1, HOLD);
    wait_rst(1'b0, 10);
    $display("test power done");
  endtask

  task automatic t_manual();
    repeat (4) begin
      manualN = 1'b0;
      keep_rst(1'b0, 40);
      manualN = 1'b1;
      keep_rst(1'b0, 40);
    end
    manualN = 1'b0;
    wait_rst(1'b1, 140);
    repeat (3) begin
      manualN = 1'b1;
      keep_rst(1'b1, 20);
      manualN = 1'b0;
      keep_rst(1'b1, 20);
    end
    manualN = 1'b1;
    keep_rst(1'b1, 125 + HOLD);
    wait_rst(1'b0, 20);
    keep_rst(1'b0, 100);
    $display("test manual done");
  endtask

  task automatic t_aux();
    cond.auxHigh = 1'b0;
    wait_rst(1'b1, 8);
    keep_rst(1'b1, 30);
    cond.auxHigh = 1'b1;
    keep_rst(1'b1, HOLD);
    wait_rst(1'b0, 10);
    $display("test aux done");
  endtask

  task automatic t_wdog();
    keep_rst(1'b0, 200);
    toggleEn = 1'b0;
    keep_rst(1'b0, WDOG - 25);
    wait_rst(1'b1, 40);
    keep_rst(1'b1, HOLD - 2);
    wait_rst(1'b0, 10);
    keep_rst(1'b0, WDOG - 5);
    wait_rst(1'b1, 15);
    wait_rst(1'b0, HOLD + 10);
    toggleEn = 1'b1;
    $display("test watchdog done");
  endtask

  task automatic t_backup();
    cond = 4'hD;
    wait_rst(1'b1, 8);
    repeat (4) @(negedge mclk);
    check("backup flag", flag, 1'b1);
    check("backup sel", selB, 1'b1);
    manualN = 1'b0;
    keep_rst(1'b1, 150);
    manualN = 1'b1;
    cond = 4'h9;
    repeat (5) @(negedge mclk);
    check("backup flag", flag, 1'b1);
    cond = 4'hB;
    repeat (5) @(negedge mclk);
    check("backup flag", flag, 1'b0);
    check("backup sel", selB, 1'b0);
    cond = 4'h5;
    repeat (5) @(negedge mclk);
    check("backup flag", flag, 1'b0);
    check("backup sel", selB, 1'b0);
    keep_rst(1'b1, 110 + HOLD);
    wait_rst(1'b0, 10);
    $display("test backup done");
  endtask

  // Free running timebase
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Main sequence, inputs moved on falling edges
  initial begin
    rstn        = 1'b0;
    manualN     = 1'b1;
    toggleEn    = 1'b1;
    cond        = 4'h1;
    fail_count  = 0;
    comparisons = 0;
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    t_power();
    t_manual();
    t_aux();
    t_wdog();
    t_backup();
    give_verdict();
  end
endmodule
